// file: inc/ddso_defines.svh
// Constants for the DRAM drive strength offset select register bank.
// Assumes an APB slave with one aligned 32-bit word per register.
`ifndef DDSO_DEFINES_SVH
`define DDSO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DDSO_IDX_MODE_SEL      8'he1
`define DDSO_IDX_DATA_DRIVE    8'he2
`define DDSO_IDX_RSVD_E3       8'he3
`define DDSO_IDX_SELECT_DRIVE  8'he4
`define DDSO_IDX_RSVD_E5       8'he5
`define DDSO_IDX_CLK0_DRIVE    8'he6
`define DDSO_IDX_CLK1_DRIVE    8'he7

// ----------------------------------------------------------------------
// Mode-select bit positions
// ----------------------------------------------------------------------
`define DDSO_MODE_ODT          0
`define DDSO_MODE_DATA         1
`define DDSO_MODE_STROBE       2
`define DDSO_MODE_SELECT       3
`define DDSO_MODE_CLK0         4
`define DDSO_MODE_CLK1         5
`define DDSO_MODE_ADDR_CMD     6

// ----------------------------------------------------------------------
// Drive register fields and reset values
// ----------------------------------------------------------------------
`define DDSO_PU_MSB            7
`define DDSO_PU_LSB            4
`define DDSO_PD_MSB            3
`define DDSO_PD_LSB            0
`define DDSO_OFS_SIGN          3
`define DDSO_MODE_SEL_RST      8'h00
`define DDSO_DRIVE_RST         8'h00
`define DDSO_BASE_MSB          7
`define DDSO_BASE_LSB          4

`endif

// file: inc/ddso_pkg.sv
// Types for the DRAM drive strength offset select register bank.
// Assumes ddso_defines.svh carries all numeric constants.
package ddso_pkg;

    typedef logic [3:0] ddso_code_t;
    typedef logic [7:0] ddso_reg_t;

    // Groups that carry their own drive register in this bank
    typedef enum logic [1:0] {
        DDSO_GRP_DATA   = 2'h0,
        DDSO_GRP_SELECT = 2'h1,
        DDSO_GRP_CLK0   = 2'h2,
        DDSO_GRP_CLK1   = 2'h3
    } ddso_group_t;

endpackage

// file: rtl/ddso_drive_regs.sv
// Drive strength register bank with manual / offset code selection.
// Assumes comp_result comes from the compensation circuit on pclk.
`timescale 1ns/1ps
`include "ddso_defines.svh"

module ddso_drive_regs (
    // Clock, reset, clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Compensation result, base code in the upper nibble
    input  wire logic [7:0]  comp_result,
    // Pad driver codes
    output logic [3:0]       data_pu_code,
    output logic [3:0]       data_pd_code,
    output logic [3:0]       select_pu_code,
    output logic [3:0]       select_pd_code,
    output logic [3:0]       clk0_pu_code,
    output logic [3:0]       clk0_pd_code,
    output logic [3:0]       clk1_pu_code,
    output logic [3:0]       clk1_pd_code,
    // Mode bits for groups whose drive registers live elsewhere
    output logic             addr_cmd_offset_mode,
    output logic             strobe_offset_mode,
    output logic             odt_offset_mode
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic                  rd_held_q;
    logic                  xfer_done;
    logic                  capture;
    logic                  write_en;
    logic                  aligned;
    logic [7:0]            idx;
    logic                  hit_mode;
    logic                  hit_rsvd;
    logic [3:0]            hit_drive;
    logic                  mapped;

    assign idx         = paddr[9:2];
    assign aligned     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign hit_mode    = aligned && (idx == `DDSO_IDX_MODE_SEL);
    // Reserved words answer without error but store nothing
    assign hit_rsvd    = aligned && ((idx == `DDSO_IDX_RSVD_E3) ||
                                     (idx == `DDSO_IDX_RSVD_E5));
    assign hit_drive[ddso_pkg::DDSO_GRP_DATA] =
        aligned && (idx == `DDSO_IDX_DATA_DRIVE);
    assign hit_drive[ddso_pkg::DDSO_GRP_SELECT] =
        aligned && (idx == `DDSO_IDX_SELECT_DRIVE);
    assign hit_drive[ddso_pkg::DDSO_GRP_CLK0] =
        aligned && (idx == `DDSO_IDX_CLK0_DRIVE);
    assign hit_drive[ddso_pkg::DDSO_GRP_CLK1] =
        aligned && (idx == `DDSO_IDX_CLK1_DRIVE);
    assign mapped      = hit_mode || hit_rsvd || (|hit_drive);

    // Writes wait only while pclk_en is low; a read waits until an enabled edge has captured
    // its word, which costs one cycle when the setup edge was frozen
    assign pready      = pclk_en && (pwrite || rd_held_q);
    assign pslverr     = psel && penable && !mapped;
    assign xfer_done   = psel && penable && pready;
    assign capture     = pclk_en && psel && !xfer_done;
    // Only the low byte lane carries data
    assign write_en    = pclk_en && psel && penable && pwrite && mapped &&
                         pstrb[0];

    // ------------------------------------------------------------------
    // Mode select register
    // ------------------------------------------------------------------
    ddso_pkg::ddso_reg_t mode_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `DDSO_MODE_SEL_RST;
        end else if (write_en && hit_mode) begin
            mode_q <= pwdata[7:0];
        end
    end

    assign addr_cmd_offset_mode = mode_q[`DDSO_MODE_ADDR_CMD];
    assign strobe_offset_mode   = mode_q[`DDSO_MODE_STROBE];
    assign odt_offset_mode      = mode_q[`DDSO_MODE_ODT];

    // ------------------------------------------------------------------
    // Offset arithmetic
    // ------------------------------------------------------------------
    function automatic ddso_pkg::ddso_code_t apply_offset(
        input ddso_pkg::ddso_code_t base,
        input ddso_pkg::ddso_code_t ofs
    );
        logic [4:0] sum;
        logic [4:0] step;
        logic [4:0] diff;
        sum  = {1'b0, base} + {2'h0, ofs[2:0]};
        step = 5'h08 - {2'h0, ofs[2:0]};
        diff = {1'b0, base} - step;
        if (!ofs[`DDSO_OFS_SIGN]) begin
            apply_offset = sum[4] ? 4'hf : sum[3:0];
        end else begin
            // Nibble 1000 gives a step of eight, not zero
            apply_offset = diff[4] ? 4'h0 : diff[3:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Per-group drive registers and code selection
    // ------------------------------------------------------------------
    ddso_pkg::ddso_code_t base_code;
    ddso_pkg::ddso_reg_t  drive_q [4];
    ddso_pkg::ddso_code_t pu_d    [4];
    ddso_pkg::ddso_code_t pd_d    [4];
    ddso_pkg::ddso_code_t pu_q    [4];
    ddso_pkg::ddso_code_t pd_q    [4];
    logic [3:0]           grp_mode;

    // Both nibbles share the one compensation base
    assign base_code = comp_result[`DDSO_BASE_MSB:`DDSO_BASE_LSB];

    assign grp_mode[ddso_pkg::DDSO_GRP_DATA]   =
        mode_q[`DDSO_MODE_DATA];
    assign grp_mode[ddso_pkg::DDSO_GRP_SELECT] =
        mode_q[`DDSO_MODE_SELECT];
    assign grp_mode[ddso_pkg::DDSO_GRP_CLK0]   =
        mode_q[`DDSO_MODE_CLK0];
    assign grp_mode[ddso_pkg::DDSO_GRP_CLK1]   =
        mode_q[`DDSO_MODE_CLK1];

    for (genvar g = 0; g < 4; g++) begin : g_grp
        ddso_pkg::ddso_code_t pu_set;
        ddso_pkg::ddso_code_t pd_set;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                drive_q[g] <= `DDSO_DRIVE_RST;
            end else if (write_en && hit_drive[g]) begin
                drive_q[g] <= pwdata[7:0];
            end
        end

        assign pu_set = drive_q[g][`DDSO_PU_MSB:`DDSO_PU_LSB];
        assign pd_set = drive_q[g][`DDSO_PD_MSB:`DDSO_PD_LSB];

        always_comb begin
            if (grp_mode[g]) begin
                pu_d[g] = apply_offset(base_code, pu_set);
                pd_d[g] = apply_offset(base_code, pd_set);
            end else begin
                pu_d[g] = pu_set;
                pd_d[g] = pd_set;
            end
        end

        // One register stage keeps the pad controls glitch free
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pu_q[g] <= 4'h0;
                pd_q[g] <= 4'h0;
            end else if (pclk_en) begin
                pu_q[g] <= pu_d[g];
                pd_q[g] <= pd_d[g];
            end
        end
    end

    assign data_pu_code   = pu_q[ddso_pkg::DDSO_GRP_DATA];
    assign data_pd_code   = pd_q[ddso_pkg::DDSO_GRP_DATA];
    assign select_pu_code = pu_q[ddso_pkg::DDSO_GRP_SELECT];
    assign select_pd_code = pd_q[ddso_pkg::DDSO_GRP_SELECT];
    assign clk0_pu_code   = pu_q[ddso_pkg::DDSO_GRP_CLK0];
    assign clk0_pd_code   = pd_q[ddso_pkg::DDSO_GRP_CLK0];
    assign clk1_pu_code   = pu_q[ddso_pkg::DDSO_GRP_CLK1];
    assign clk1_pd_code   = pd_q[ddso_pkg::DDSO_GRP_CLK1];

    // ------------------------------------------------------------------
    // Read data, captured at the first enabled edge of a transfer
    // ------------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_mode) begin
            rdata_d = {24'h00_0000, mode_q};
        end else if (hit_drive[ddso_pkg::DDSO_GRP_DATA]) begin
            rdata_d = {24'h00_0000, drive_q[ddso_pkg::DDSO_GRP_DATA]};
        end else if (hit_drive[ddso_pkg::DDSO_GRP_SELECT]) begin
            rdata_d = {24'h00_0000, drive_q[ddso_pkg::DDSO_GRP_SELECT]};
        end else if (hit_drive[ddso_pkg::DDSO_GRP_CLK0]) begin
            rdata_d = {24'h00_0000, drive_q[ddso_pkg::DDSO_GRP_CLK0]};
        end else if (hit_drive[ddso_pkg::DDSO_GRP_CLK1]) begin
            rdata_d = {24'h00_0000, drive_q[ddso_pkg::DDSO_GRP_CLK1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (capture) begin
            rdata_q <= rdata_d;
        end
    end

    // Set once the word of the current transfer is held, cleared as the
    // transfer completes so that the next one captures afresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_held_q <= 1'b0;
        end else if (xfer_done) begin
            rd_held_q <= 1'b0;
        end else if (capture) begin
            rd_held_q <= 1'b1;
        end
    end

    assign prdata = rdata_q;

endmodule

// file: tb/ddso_comp_model.sv
// Stand-in for the compensation circuit feeding the base code.
// Assumes the bench chooses the base on base_set.
`timescale 1ns/1ps
module ddso_comp_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] base_set,
    output logic      [7:0] comp_result
);
    // Low nibble is no base; it churns so nothing may lean on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_result <= 8'h00;
        end else begin
            comp_result <= {base_set, ~comp_result[3:0] + 4'h3};
        end
    end
endmodule

// file: tb/ddso_drive_regs_sva.sv
// Port checker for the drive strength register bank.
// Assumes one clock; pclk_en may freeze the bank for whole cycles.
`timescale 1ns/1ps
module ddso_drive_regs_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pclk_en,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  pstrb,
    // Compensation and pad side
    input wire logic [7:0]  comp_result,
    input wire logic [3:0]  data_pu_code,
    input wire logic [3:0]  data_pd_code,
    input wire logic [3:0]  select_pu_code,
    input wire logic [3:0]  select_pd_code,
    input wire logic [3:0]  clk0_pu_code,
    input wire logic [3:0]  clk0_pd_code,
    input wire logic [3:0]  clk1_pu_code,
    input wire logic [3:0]  clk1_pd_code,
    input wire logic        addr_cmd_offset_mode,
    input wire logic        strobe_offset_mode,
    input wire logic        odt_offset_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] sh [0:7];
    logic       ok;
    function automatic logic [7:0] pk(logic m, logic [7:0] r, logic [3:0] b);
        int u;
        int d;
        u = int'(b) + int'(r[6:4]) - (r[7] ? 8 : 0);
        d = int'(b) + int'(r[2:0]) - (r[3] ? 8 : 0);
        u = u > 15 ? 15 : (u < 0 ? 0 : u);
        d = d > 15 ? 15 : (d < 0 ? 0 : d);
        return m ? {u[3:0], d[3:0]} : r;
    endfunction
    assign ok = paddr[11:5] == 7'h1c && paddr[1:0] == 2'h0 &&
                paddr[4:2] != 3'h0;
    // Reserved slots never take a write, so they read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) sh[i] <= 8'h00;
        end else if (psel && penable && pwrite && pclk_en && pstrb[0] && ok
                     && paddr[4:2] != 3'h3 && paddr[4:2] != 3'h5) begin
            sh[paddr[4:2]] <= pwdata[7:0];
        end
    end
    // A frozen edge must leave the pad codes exactly as they were
    chk_data_codes: assert property (
        {data_pu_code, data_pd_code} == ($past(pclk_en) ?
        pk($past(sh[1][1]), $past(sh[2]), $past(comp_result[7:4])) :
        $past({data_pu_code, data_pd_code})))
        else $error("data group code wrong");
    chk_select_codes: assert property (
        {select_pu_code, select_pd_code} == ($past(pclk_en) ?
        pk($past(sh[1][3]), $past(sh[4]), $past(comp_result[7:4])) :
        $past({select_pu_code, select_pd_code})))
        else $error("select group code wrong");
    chk_clk0_codes: assert property (
        {clk0_pu_code, clk0_pd_code} == ($past(pclk_en) ?
        pk($past(sh[1][4]), $past(sh[6]), $past(comp_result[7:4])) :
        $past({clk0_pu_code, clk0_pd_code})))
        else $error("clock 0 code wrong");
    chk_clk1_codes: assert property (
        {clk1_pu_code, clk1_pd_code} == ($past(pclk_en) ?
        pk($past(sh[1][5]), $past(sh[7]), $past(comp_result[7:4])) :
        $past({clk1_pu_code, clk1_pd_code})))
        else $error("clock 1 code wrong");
    chk_mode_outs: assert property (
        {addr_cmd_offset_mode, strobe_offset_mode, odt_offset_mode}
        == {sh[1][6], sh[1][2], sh[1][0]}) else $error("mode output wrong");
    chk_read_data: assert property (
        psel && penable && pready && !pwrite |->
        prdata == (ok ? {24'h0, sh[paddr[4:2]]}
        : 32'h0)) else $error("read data wrong");
    chk_unmapped_err: assert property (
        psel && penable |-> pslverr == !ok) else $error("error flag wrong");
    chk_reset_codes: assert property (
        $rose(presetn) |-> {data_pu_code, select_pd_code, clk1_pu_code} == 12'h0
        ) else $error("codes not clear after reset");
    chk_write_no_wait: assert property (
        psel && penable && pwrite |-> pready == pclk_en
        ) else $error("write answer wrong");
    chk_read_stall: assert property (
        psel && penable && !pwrite && $past(psel && !penable && !pclk_en)
        |-> !pready) else $error("read answered before capture");
endmodule
bind ddso_drive_regs ddso_drive_regs_chk ddso_drive_regs_chk_inst (.*);

// file: tb/ddso_drive_regs_tb.sv
// Bench for the drive strength register bank over APB.
// Assumes the compensation model and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module ddso_drive_regs_tb;
    logic        pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, base, a, b, c, d, e, f, g, h;
    logic [7:0]  comp_result, rv;
    logic [31:0] ex;
    logic        m_ac, m_st, m_odt;
    int          err_total, tests_run;
    logic [3:0]  nb [8] = '{4'h2, 4'h7, 4'h8, 4'hf, 4'h9, 4'h0, 4'he, 4'hc};
    logic [3:0]  bs [8] = '{4'h0, 4'h1, 4'h5, 4'h7, 4'h8, 4'hd, 4'he, 4'hf};
    logic [7:0]  md [7] = '{8'h00, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40,
                            8'hbf};
    int          ix [4] = '{2, 4, 6, 7};
    int          gb [4] = '{1, 3, 4, 5};
    ddso_comp_model ddso_comp_model_inst (.pclk(pclk), .presetn(presetn),
        .base_set(base), .comp_result(comp_result));
    ddso_drive_regs ddso_drive_regs_inst (.pclk(pclk), .presetn(presetn),
        .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .comp_result(comp_result),
        .data_pu_code(a), .data_pd_code(b), .select_pu_code(c),
        .select_pd_code(d), .clk0_pu_code(e), .clk0_pd_code(f),
        .clk1_pu_code(g), .clk1_pd_code(h), .addr_cmd_offset_mode(m_ac),
        .strobe_offset_mode(m_st), .odt_offset_mode(m_odt));
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [3:0] xc(logic m, logic [3:0] n, logic [3:0] s);
        int v;
        v = n[3] ? int'(s) - 8 + int'(n[2:0]) : int'(s) + int'(n[2:0]);
        return !m ? n : (v > 15 ? 4'hf : (v < 0 ? 4'h0 : v[3:0]));
    endfunction
    function automatic logic [11:0] ad(int i);
        return {7'h1c, 3'(i), 2'h0};
    endfunction
    task close_out;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One transfer, then an idle cycle so no signal is set twice at an edge
    task apb(logic w, logic [11:0] ar, logic [7:0] dt, logic s, logic er,
             logic [7:0] xp);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ar;
        pwdata <= {24'h0, dt};
        pstrb <= w ? {3'h0, s} : 4'h0;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin err_total++; close_out; end
        if (!w) `CHK(prdata, {24'h0, xp})
        `CHK(pslverr, er)
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    initial begin
        presetn = 0; pclk_en = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; pstrb = 0; base = 0; err_total = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 1; i < 8; i++) apb(0, ad(i), 0, 1, 0, 8'h00);
        for (int i = 1; i < 8; i++) apb(1, ad(i), 8'ha5, 1, 0, 0);
        for (int i = 1; i < 8; i++) apb(0, ad(i), 0, 1, 0,
            (i == 3 || i == 5) ? 8'h00 : 8'ha5);
        apb(1, ad(2), 8'h11, 0, 0, 0);
        apb(0, ad(2), 0, 1, 0, 8'ha5);
        apb(1, 12'h380, 8'h11, 1, 1, 0);
        apb(0, 12'h3a0, 0, 1, 1, 8'h00);
        for (int mi = 0; mi < 7; mi++) begin
            apb(1, ad(1), md[mi], 1, 0, 0);
            apb(0, ad(1), 0, 1, 0, md[mi]);
            `CHK({m_ac, m_st, m_odt}, {md[mi][6], md[mi][2], md[mi][0]})
            for (int t = 0; t < 8; t++) begin
                base <= bs[t];
                for (int k = 0; k < 4; k++) begin
                    rv = {nb[(t + k) % 8], nb[(t + k + 3) % 8]};
                    apb(1, ad(ix[k]), rv, 1, 0, 0);
                    ex[31 - 8 * k -: 8] = {xc(md[mi][gb[k]], rv[7:4], bs[t]),
                                           xc(md[mi][gb[k]], rv[3:0], bs[t])};
                end
                repeat (2) @(posedge pclk);
                `CHK({a, b, c, d, e, f, g, h}, ex)
            end
        end
        // Frozen clock: codes hold while the base moves, transfers wait
        pclk_en <= 0;
        base <= 4'h0;
        fork
            apb(1, ad(2), 8'h3c, 1, 0, 0);
            begin
                repeat (4) @(posedge pclk);
                `CHK({a, b, c, d, e, f, g, h}, ex)
                pclk_en <= 1;
            end
        join
        pclk_en <= 0;
        fork
            apb(0, ad(2), 0, 1, 0, 8'h3c);
            begin
                repeat (3) @(posedge pclk);
                pclk_en <= 1;
            end
        join
        `CHK({a, b}, {xc(md[6][1], 4'h3, 4'h0), xc(md[6][1], 4'hc, 4'h0)})
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 1; i < 8; i++) apb(0, ad(i), 0, 1, 0, 8'h00);
        `CHK({a, b, c, d, e, f, g, h}, 32'h0)
        close_out;
    end
endmodule
